// ==== hw/sfr_guard.sv ====
// Functional notes
// - MMU config registers reachable only in System Mode
// - Segment table pointer written only in System
// - System Mode reaches hardware component registers
// - User Mode gets only CPU registers by default
// - User access to component register needs grant
// - Reset loads every register value and attribute
// - Reset leaves restrictive MMU attributes before software
// - Only user/firmware component rights are programmable
// - Attribute updates accepted only from privileged mode
// - Key flush clears all derived key registers
module sfr_guard
	import sfr_guard_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [ADDR_W-1:0] acc_addr,
	input wire logic [DATA_W-1:0] acc_wdata,
	input wire logic [1:0] acc_mode,
	input wire logic kdf_load,
	input wire logic [KEY_W-1:0] kdf_key,
	output logic acc_done_ff,
	output logic [DATA_W-1:0] acc_rdata_ff,
	output logic violation_ff,
	output logic [KEY_W-1:0] key_ff
);

	logic [DATA_W-1:0] sfr_ff [NUM_SFR];
	logic [DATA_W-1:0] nxt_sfr [NUM_SFR];
	logic nxt_done;
	logic nxt_violation;
	logic [DATA_W-1:0] nxt_rdata;
	logic [KEY_W-1:0] nxt_key;
	// Flat view of the register file, read only by the checks below
	wire logic [NUM_SFR*DATA_W-1:0] sfr_flat;

	// Decode of mode and register class; the class map is wiring only,
	// so no software path can move a register into another class
	wire logic mode_sys = (acc_mode == MODE_SYS);
	wire logic mode_fw = (acc_mode == MODE_FW);
	wire logic mode_user = (acc_mode == MODE_USER);
	wire logic is_cpu = (acc_addr[3:2] == CLS_CPU);
	wire logic is_mmu = (acc_addr[3:2] == CLS_MMU);
	wire logic is_hw = acc_addr[3];
	wire logic [2:0] hw_idx = acc_addr[2:0];
	wire logic [DATA_W-1:0] usr_grant = sfr_ff[USR_GRANT];
	wire logic [DATA_W-1:0] fw_grant = sfr_ff[FW_GRANT];

	wire logic cpu_ok = is_cpu && (mode_sys || mode_fw || mode_user);
	wire logic mmu_ok = is_mmu && mode_sys;
	wire logic hw_ok = is_hw && (mode_sys
		|| (mode_fw && fw_grant[hw_idx])
		|| (mode_user && usr_grant[hw_idx]));
	wire logic allow = cpu_ok || mmu_ok || hw_ok;
	wire logic wr_ok = acc_valid && acc_write && allow;
	wire logic denied = acc_valid && !allow;

	// A flush takes priority over a fresh key load in the same cycle,
	// so a key can never survive a request to destroy it
	wire logic flush = wr_ok && (acc_addr == KDF_CTRL)
		&& acc_wdata[FLUSH_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SFR; gi++) begin : g_sfr
			localparam logic [ADDR_W-1:0] IDX = ADDR_W'(gi);
			localparam bit IS_KEY = (gi >= KEY_BASE);
			localparam int KB = IS_KEY ? gi - KEY_BASE : 0;
			wire logic hit = wr_ok && (acc_addr == IDX);
			assign sfr_flat[gi*DATA_W +: DATA_W] = sfr_ff[gi];
			assign nxt_sfr[gi] =
				(IS_KEY && flush) ? '0 :
				(IS_KEY && kdf_load) ? kdf_key[KB*DATA_W +: DATA_W] :
				hit ? acc_wdata : sfr_ff[gi];
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					sfr_ff[gi] <= SFR_RST[gi*DATA_W +: DATA_W];
				end else begin
					sfr_ff[gi] <= nxt_sfr[gi];
				end
			end
		end
	endgenerate

	// Denied reads return zero so nothing leaks through the data path
	assign nxt_done = acc_valid;
	assign nxt_violation = denied;
	assign nxt_rdata = (acc_valid && !acc_write && allow) ?
		sfr_ff[acc_addr] : '0;
	assign nxt_key = {nxt_sfr[KEY_BASE+3], nxt_sfr[KEY_BASE+2],
		nxt_sfr[KEY_BASE+1], nxt_sfr[KEY_BASE]};

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			acc_done_ff <= 1'b0;
			violation_ff <= 1'b0;
			acc_rdata_ff <= '0;
			key_ff <= '0;
		end else begin
			acc_done_ff <= nxt_done;
			violation_ff <= nxt_violation;
			acc_rdata_ff <= nxt_rdata;
			key_ff <= nxt_key;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_mmu_sys_only;
		acc_valid && is_mmu && !mode_sys |=> violation_ff && acc_rdata_ff == '0;
	endproperty
	a_mmu_sys_only: assert property (p_mmu_sys_only)
		else $error("MMU register reached outside System Mode");

	property p_seg_ptr_hold;
		acc_valid && acc_write && acc_addr == SEG_PTR && !mode_sys
			|=> $stable(sfr_ff[SEG_PTR]);
	endproperty
	a_seg_ptr_hold: assert property (p_seg_ptr_hold)
		else $error("Segment pointer changed outside System Mode");

	property p_hw_sys;
		acc_valid && is_hw && mode_sys |=> acc_done_ff && !violation_ff;
	endproperty
	a_hw_sys: assert property (p_hw_sys)
		else $error("System Mode refused a component register");

	property p_user_default;
		acc_valid && mode_user && is_hw && !usr_grant[hw_idx]
			|=> violation_ff;
	endproperty
	a_user_default: assert property (p_user_default)
		else $error("Ungranted component register open to User Mode");

	property p_user_grant;
		acc_valid && !acc_write && mode_user && is_hw && usr_grant[hw_idx]
			|=> !violation_ff && acc_rdata_ff == $past(sfr_ff[acc_addr]);
	endproperty
	a_user_grant: assert property (p_user_grant)
		else $error("Granted User read not served");

	property p_reset_defaults;
		$rose(reset_n) |-> sfr_ff[1] == SFR_RST[DATA_W +: DATA_W]
			&& key_ff == '0
			&& !violation_ff && !acc_done_ff;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("Register defaults missing after reset");

	property p_reset_restrictive;
		$rose(reset_n) |-> sfr_ff[SEG_PTR] == '0 && usr_grant == '0
			&& fw_grant == '0;
	endproperty
	a_reset_restrictive: assert property (p_reset_restrictive)
		else $error("MMU attributes not restrictive after reset");

	property p_cpu_fixed;
		acc_valid && is_cpu && acc_mode != MODE_BAD |=> !violation_ff;
	endproperty
	a_cpu_fixed: assert property (p_cpu_fixed)
		else $error("CPU register rights changed");

	property p_attr_priv;
		acc_valid && acc_write && !mode_sys
			&& (acc_addr == USR_GRANT || acc_addr == FW_GRANT)
			|=> $stable(usr_grant) && $stable(fw_grant);
	endproperty
	a_attr_priv: assert property (p_attr_priv)
		else $error("Grant mask updated from unprivileged mode");

	property p_flush;
		flush |=> key_ff == '0 ##1 key_ff == '0 || $past(kdf_load)
			|| $past(wr_ok && acc_addr >= KEY_BASE);
	endproperty
	a_flush: assert property (p_flush)
		else $error("Key registers not cleared by flush");

	property p_deny_hold;
		denied && acc_write && !(kdf_load && acc_addr >= KEY_BASE)
			|=> violation_ff && sfr_ff[$past(acc_addr)]
				== $past(sfr_ff[acc_addr]);
	endproperty
	a_deny_hold: assert property (p_deny_hold)
		else $error("Denied write altered register or missed flag");

	property p_bad_mode;
		acc_valid && acc_mode == MODE_BAD |=> violation_ff;
	endproperty
	a_bad_mode: assert property (p_bad_mode)
		else $error("Access with undefined mode accepted");

	property p_sys_mmu;
		acc_valid && is_mmu && mode_sys |=> acc_done_ff && !violation_ff;
	endproperty
	a_sys_mmu: assert property (p_sys_mmu)
		else $error("System Mode refused an MMU register");

	property p_seg_ptr_sys;
		acc_valid && acc_write && mode_sys && acc_addr == SEG_PTR
			|=> sfr_ff[SEG_PTR] == $past(acc_wdata);
	endproperty
	a_seg_ptr_sys: assert property (p_seg_ptr_sys)
		else $error("System write to segment pointer lost");

	property p_hw_sys_read;
		acc_valid && !acc_write && is_hw && mode_sys
			|=> acc_rdata_ff == $past(sfr_ff[acc_addr]);
	endproperty
	a_hw_sys_read: assert property (p_hw_sys_read)
		else $error("System read of component register wrong");

	property p_user_cpu;
		acc_valid && mode_user && is_cpu |=> acc_done_ff && !violation_ff;
	endproperty
	a_user_cpu: assert property (p_user_cpu)
		else $error("User Mode refused a CPU register");

	// A key load outranks a write to a key register in the same cycle
	property p_user_wr_grant;
		acc_valid && acc_write && mode_user && is_hw && usr_grant[hw_idx]
			&& !(kdf_load && acc_addr >= KEY_BASE)
			|=> sfr_ff[$past(acc_addr)] == $past(acc_wdata);
	endproperty
	a_user_wr_grant: assert property (p_user_wr_grant)
		else $error("Granted User write not taken");

	property p_reset_image;
		$rose(reset_n) |-> sfr_flat == SFR_RST;
	endproperty
	a_reset_image: assert property (p_reset_image)
		else $error("Register image differs from reset defaults");

	property p_reset_quiet;
		$rose(reset_n) |-> acc_rdata_ff == '0 && !acc_done_ff;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("Access outputs active right after reset");

	property p_fw_default;
		acc_valid && mode_fw && is_hw && !fw_grant[hw_idx] |=> violation_ff;
	endproperty
	a_fw_default: assert property (p_fw_default)
		else $error("Ungranted component register open to Firmware");

	property p_fw_grant;
		acc_valid && !acc_write && mode_fw && is_hw && fw_grant[hw_idx]
			|=> !violation_ff && acc_rdata_ff == $past(sfr_ff[acc_addr]);
	endproperty
	a_fw_grant: assert property (p_fw_grant)
		else $error("Granted Firmware read not served");

	property p_usr_grant_sys;
		acc_valid && acc_write && mode_sys && acc_addr == USR_GRANT
			|=> usr_grant == $past(acc_wdata);
	endproperty
	a_usr_grant_sys: assert property (p_usr_grant_sys)
		else $error("System write to User grant mask lost");

	property p_fw_grant_sys;
		acc_valid && acc_write && mode_sys && acc_addr == FW_GRANT
			|=> fw_grant == $past(acc_wdata);
	endproperty
	a_fw_grant_sys: assert property (p_fw_grant_sys)
		else $error("System write to Firmware grant mask lost");

	property p_kdf_load;
		kdf_load && !flush |=> key_ff == $past(kdf_key);
	endproperty
	a_kdf_load: assert property (p_kdf_load)
		else $error("Derived key not loaded");

	property p_flush_regs;
		flush |=> sfr_flat[NUM_SFR*DATA_W-1 -: KEY_W] == '0;
	endproperty
	a_flush_regs: assert property (p_flush_regs)
		else $error("Key registers survived a flush");

	property p_key_mirror;
		key_ff == sfr_flat[NUM_SFR*DATA_W-1 -: KEY_W];
	endproperty
	a_key_mirror: assert property (p_key_mirror)
		else $error("Key output differs from key registers");

	property p_deny_read;
		denied && !acc_write |=> violation_ff && acc_rdata_ff == '0;
	endproperty
	a_deny_read: assert property (p_deny_read)
		else $error("Denied read returned data or missed flag");

	property p_allow_clean;
		acc_valid && allow |=> acc_done_ff && !violation_ff;
	endproperty
	a_allow_clean: assert property (p_allow_clean)
		else $error("Allowed access raised a violation");

	// Access outputs are pulses, so an idle cycle must leave done, violation and read data low
	property p_idle_quiet;
		!acc_valid |=> !acc_done_ff && !violation_ff && acc_rdata_ff == '0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("Access outputs active without a request");

	property p_write_no_data;
		acc_valid && acc_write |=> acc_rdata_ff == '0;
	endproperty
	a_write_no_data: assert property (p_write_no_data)
		else $error("Write returned read data");

	property p_done;
		acc_valid |=> acc_done_ff;
	endproperty
	a_done: assert property (p_done)
		else $error("Access not acknowledged");

endmodule : sfr_guard

// ==== hw/sfr_guard_pkg.sv ====
package sfr_guard_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NUM_SFR = 16;
	localparam int NUM_HW = 8;
	localparam int KEY_BYTES = 4;
	localparam int KEY_W = KEY_BYTES * DATA_W;

	// Privilege mode presented by the CPU with every access
	typedef enum logic [1:0] {
		MODE_SYS = 2'h0,
		MODE_FW = 2'h1,
		MODE_USER = 2'h3,
		MODE_BAD = 2'h2
	} mode_t;

	// Register classes are fixed by address bits
	localparam logic [1:0] CLS_CPU = 2'h0;
	localparam logic [1:0] CLS_MMU = 2'h1;

	// MMU configuration block
	localparam logic [ADDR_W-1:0] SEG_PTR = 4'h4;
	localparam logic [ADDR_W-1:0] USR_GRANT = 4'h5;
	localparam logic [ADDR_W-1:0] FW_GRANT = 4'h6;
	localparam logic [ADDR_W-1:0] MMU_CTRL = 4'h7;

	// Hardware component block
	localparam logic [ADDR_W-1:0] COPRO_CTRL = 4'h8;
	localparam logic [ADDR_W-1:0] RNG_DATA = 4'h9;
	localparam logic [ADDR_W-1:0] COPRO_DATA = 4'ha;
	localparam logic [ADDR_W-1:0] KDF_CTRL = 4'hb;
	localparam logic [ADDR_W-1:0] KEY_BASE = 4'hc;
	localparam int FLUSH_BIT = 0;

	// Reset contents, entry i at bits [8*i +: 8]; segment pointer and
	// both grant masks clear, so no segment and no User or Firmware component access exist
	localparam logic [NUM_SFR*DATA_W-1:0] SFR_RST =
		128'h0000_0000_0000_0000_0000_0000_0000_0700;

endpackage : sfr_guard_pkg

// ==== test/cpu_core_model.sv ====
module cpu_core_model
	import sfr_guard_pkg::*;
(
	input wire logic clk,
	output logic acc_valid,
	output logic acc_write,
	output logic [ADDR_W-1:0] acc_addr,
	output logic [DATA_W-1:0] acc_wdata,
	output logic [1:0] acc_mode
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		{acc_valid, acc_write, acc_addr, acc_wdata, acc_mode} = '0;
	end

	// Mode travels with the request so the guard judges that very cycle
	task automatic access(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [1:0] m);
		@(negedge clk);
		acc_valid = 1'b1;
		acc_write = w;
		acc_addr = a;
		acc_wdata = d;
		acc_mode = m;
		@(negedge clk);
		acc_valid = 1'b0;
		// Stale data is inverted so nothing can lean on it after the request
		acc_wdata = ~d;
	endtask : access
endmodule : cpu_core_model

// ==== test/tb_top.sv ====
module tb_top
	import sfr_guard_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic kdf_load = 1'b0;
	logic [KEY_W-1:0] kdf_key = '0;
	logic acc_valid, acc_write, acc_done_ff, violation_ff;
	logic [ADDR_W-1:0] acc_addr;
	logic [1:0] acc_mode;
	logic [DATA_W-1:0] acc_wdata, acc_rdata_ff;
	logic [KEY_W-1:0] key_ff;
	logic [DATA_W-1:0] shadow [NUM_SFR];
	logic [31:0] seed = 32'hace67552;
	logic [31:0] r;
	int n_fail = 0;
	int checks = 0;

	always #20 clk = ~clk;

	cpu_core_model cpu_core_model_i (.clk, .acc_valid, .acc_write, .acc_addr,
		.acc_wdata, .acc_mode);
	sfr_guard sfr_guard_i (.clk, .reset_n, .acc_valid, .acc_write, .acc_addr,
		.acc_wdata, .acc_mode, .kdf_load, .kdf_key, .acc_done_ff,
		.acc_rdata_ff, .violation_ff, .key_ff);

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	function automatic logic allowed(input logic [3:0] a, input logic [1:0] m);
		if (m == MODE_BAD) return 1'b0;
		if (a < 4'h4) return 1'b1;
		if (m == MODE_SYS) return 1'b1;
		if (a < 4'h8) return 1'b0;
		if (m == MODE_FW) return shadow[FW_GRANT][a[2:0]];
		return shadow[USR_GRANT][a[2:0]];
	endfunction : allowed

	task automatic check(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic [1:0] m);
		logic ok;
		logic [7:0] exp_rd;
		logic [31:0] exp_key;
		ok = allowed(a, m);
		exp_rd = (ok && !w) ? shadow[a] : 8'h00;
		cpu_core_model_i.access(w, a, d, m);
		check("done", acc_done_ff, 1'b1);
		check("violation", violation_ff, !ok);
		check("rdata", acc_rdata_ff, exp_rd);
		if (ok && w) begin
			shadow[a] = d;
			if (a == KDF_CTRL && d[FLUSH_BIT]) begin
				for (int i = 12; i < 16; i++) shadow[i] = '0;
			end
		end
		exp_key = {shadow[15], shadow[14], shadow[13], shadow[12]};
		check("key", key_ff, exp_key);
	endtask : acc

	task automatic kdf(input logic [31:0] k);
		@(negedge clk);
		kdf_load = 1'b1;
		kdf_key = k;
		@(negedge clk);
		kdf_load = 1'b0;
		for (int i = 0; i < 4; i++) shadow[12+i] = k[8*i +: 8];
		check("key load", key_ff, k);
	endtask : kdf

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		check("done after reset", acc_done_ff, 1'b0);
		for (int i = 0; i < NUM_SFR; i++) shadow[i] = SFR_RST[8*i +: 8];
		for (int a = 0; a < 16; a++) acc(1'b0, 4'(a), 8'h00, MODE_SYS);
		$display("test reset values done");
		// Every mode but System against every guarded register before any grant
		for (int m = 1; m < 4; m++) begin
			for (int a = 4; a < 16; a++) begin
				acc(1'b1, 4'(a), 8'(rnd()), 2'(m));
			end
		end
		$display("test default denial done");
		for (int i = 0; i < 300; i++) begin
			r = rnd();
			if (r[22:20] == 3'h0) kdf(rnd());
			// Mask data drawn apart from the selector bits, so all grant
			// bits get exercised
			if (r[26:23] == 4'h0) begin
				acc(1'b1, 4'(5 + r[27]), 8'(rnd()), MODE_SYS);
			end
			acc(r[0], r[7:4], r[15:8], r[17:16]);
		end
		$display("test random traffic done");
		// Reset again with grants and keys set, so defaults must return
		@(negedge clk);
		reset_n = 1'b0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		check("key after reset", key_ff, 32'h0000_0000);
		for (int i = 0; i < NUM_SFR; i++) shadow[i] = SFR_RST[8*i +: 8];
		acc(1'b0, USR_GRANT, 8'h00, MODE_SYS);
		acc(1'b0, FW_GRANT, 8'h00, MODE_SYS);
		acc(1'b0, RNG_DATA, 8'h00, MODE_USER);
		acc(1'b0, RNG_DATA, 8'h00, MODE_FW);
		$display("test second reset done");
		kdf(32'h5a3c_96e1);
		acc(1'b1, KDF_CTRL, 8'h01, MODE_SYS);
		acc(1'b0, KDF_CTRL, 8'h00, MODE_SYS);
		$display("test key flush done");
		end_of_test();
	end
endmodule : tb_top
